// >>> logic/wps_cfg.svh
`ifndef WPS_CFG_SVH
`define WPS_CFG_SVH

`define WPS_WORD_W 16
`define WPS_ANA_W 14
`define WPS_MARK_LSB 0
`define WPS_ANA_LSB 2
`define WPS_GRAN 16
`define WPS_GRAN_W 4
`define WPS_ADDR_W 12
`define WPS_PC_W 8
`define WPS_CNT_W 16
`define WPS_NTRIG 4
`define WPS_NSRC 8
`define WPS_SEL_W 3
`define WPS_OP_W 3
`define WPS_ARG_W 16
`define WPS_ANA_MID 14'h2000
`define WPS_AMP_SHIFT 13

`endif

// >>> logic/wps_pkg.sv
`include "wps_cfg.svh"

package wps_pkg;

    typedef enum logic [`WPS_OP_W-1:0] {
        WPS_OP_END,
        WPS_OP_PLAY,
        WPS_OP_WAIT,
        WPS_OP_LOOP,
        WPS_OP_JUMP
    } wps_op_t;

    // One sequencer instruction
    typedef struct packed {
        wps_op_t op;
        logic [`WPS_PC_W-1:0] target;
        logic [`WPS_ARG_W-1:0] arg_a;
        logic [`WPS_ARG_W-1:0] arg_b;
    } wps_instr_t;

    // One output sample toward the converter path
    typedef struct packed {
        logic valid;
        logic [`WPS_ANA_W-1:0] analog;
        logic [1:0] marker;
    } wps_sample_t;

    // Queued playback request
    typedef struct packed {
        logic [`WPS_ADDR_W-1:0] base;
        logic [`WPS_CNT_W-1:0] length;
    } wps_play_t;

endpackage

// >>> logic/wps_player.sv
`timescale 1ns/100ps
`include "wps_cfg.svh"

module wps_player
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Request from sequencer
    input wire logic req_valid,
    input wire wps_pkg::wps_play_t req,
    output logic req_ready,
    output logic busy,
    // Sample memory
    output logic [`WPS_ADDR_W-1:0] mem_addr,
    input wire logic [`WPS_WORD_W-1:0] mem_data,
    // Sample out
    output wps_pkg::wps_sample_t sample
);
    import wps_pkg::*;

    ////////////////////////////////////////////////////////////////////
    wps_play_t cur_q;
    wps_play_t nxt_q;
    logic cur_v_q;
    logic nxt_v_q;
    logic [`WPS_CNT_W-1:0] idx_q;
    logic [`WPS_CNT_W-1:0] padlen;
    logic last;

    // Padding to the granule keeps back-to-back timing fixed
    assign padlen = {cur_q.length[`WPS_CNT_W-1:`WPS_GRAN_W] +
        (cur_q.length[`WPS_GRAN_W-1:0] != '0 ? 12'h001 : 12'h000),
        4'h0};
    assign last = cur_v_q && (idx_q + 16'h0001 >= padlen);
    assign req_ready = !nxt_v_q;
    assign busy = cur_v_q || nxt_v_q;
    assign mem_addr = cur_q.base + idx_q[`WPS_ADDR_W-1:0];

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            cur_v_q <= 1'b0;
            nxt_v_q <= 1'b0;
            idx_q <= '0;
            cur_q <= '0;
            nxt_q <= '0;
        end
        else
        begin
            if (req_valid && req_ready)
            begin
                nxt_q <= req;
                nxt_v_q <= 1'b1;
            end
            if (!cur_v_q || last)
            begin
                // Promote queued play with no idle cycle
                idx_q <= '0;
                cur_v_q <= nxt_v_q;
                cur_q <= nxt_q;
                if (nxt_v_q)
                    nxt_v_q <= req_valid && req_ready;
                if (nxt_v_q && req_valid && req_ready)
                    nxt_q <= req;
            end
            else
                idx_q <= idx_q + 16'h0001;
        end
    end

    // Marker and analog leave in the same register stage
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            sample <= '0;
        else if (cur_v_q && idx_q < cur_q.length)
        begin
            sample.valid <= 1'b1;
            sample.marker <= mem_data[`WPS_MARK_LSB +: 2];
            sample.analog <= mem_data[`WPS_ANA_LSB +: `WPS_ANA_W];
        end
        else
        begin
            sample.valid <= cur_v_q;
            sample.marker <= 2'h0;
            sample.analog <= `WPS_ANA_MID;
        end
    end

    property p_mark_align;
        @(posedge sys_clk) disable iff (!rst_b)
        cur_v_q && idx_q < cur_q.length |=>
        sample.marker == $past(mem_data[`WPS_MARK_LSB +: 2]);
    endproperty
    a_mark_align: assert property (p_mark_align)
        else $error("marker not aligned with sample");
    property p_analog;
        @(posedge sys_clk) disable iff (!rst_b)
        cur_v_q && idx_q < cur_q.length |=>
        sample.analog == $past(mem_data[`WPS_ANA_LSB +: `WPS_ANA_W]);
    endproperty
    a_analog: assert property (p_analog)
        else $error("analog word not passed through");
    property p_pad_mid;
        @(posedge sys_clk) disable iff (!rst_b)
        cur_v_q && idx_q >= cur_q.length |=> sample.valid &&
        sample.marker == 2'h0 && sample.analog == `WPS_ANA_MID;
    endproperty
    a_pad_mid: assert property (p_pad_mid)
        else $error("padding sample not mid scale");
    property p_in_pad;
        @(posedge sys_clk) disable iff (!rst_b)
        cur_v_q |-> idx_q < padlen || padlen == '0;
    endproperty
    a_in_pad: assert property (p_in_pad)
        else $error("index ran past padded length");
    property p_gapless;
        @(posedge sys_clk) disable iff (!rst_b)
        cur_v_q && last && nxt_v_q |=> cur_v_q && idx_q == '0;
    endproperty
    a_gapless: assert property (p_gapless)
        else $error("gap between queued waveforms");
endmodule

// >>> logic/wps_sequencer.sv
`timescale 1ns/100ps
`include "wps_cfg.svh"

module wps_sequencer
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Loader
    input wire logic load_we,
    input wire logic [`WPS_PC_W-1:0] load_addr,
    input wire wps_pkg::wps_instr_t load_instr,
    input wire logic load_done,
    input wire logic load_error,
    output logic compile_ok_indicator,
    // Control
    input wire logic start,
    input wire logic rerun_en,
    input wire logic seq_reset,
    output logic running,
    // Triggers
    input wire logic [`WPS_NSRC-1:0] trig_src,
    input wire logic [`WPS_NTRIG*`WPS_SEL_W-1:0] trig_sel,
    output logic [`WPS_NTRIG-1:0] trig_level,
    // Range scaling
    input wire logic [15:0] full_scale_level,
    output logic signed [15:0] out_level,
    // Sample memory and output
    output logic [`WPS_ADDR_W-1:0] mem_addr,
    input wire logic [`WPS_WORD_W-1:0] mem_data,
    output wps_pkg::wps_sample_t sample
);
    import wps_pkg::*;

    ////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {WPS_IDLE, WPS_EXEC, WPS_WAIT} wps_state_t;

    wps_instr_t prog_q [0:(1<<`WPS_PC_W)-1];
    wps_instr_t ins;
    wps_state_t state_q;
    logic [`WPS_PC_W-1:0] pc_q;
    logic [`WPS_CNT_W-1:0] loop_q;
    logic loop_v_q;
    logic loaded_q;
    logic play_valid;
    logic play_ready;
    logic busy;
    logic [`WPS_SEL_W-1:0] sel;
    logic [`WPS_NSRC-1:0] s1_q, s2_q, s3_q, trsync_q;
    logic [`WPS_CNT_W-1:0] loop_init;
    logic signed [31:0] amp_prod;

    assign ins = prog_q[pc_q];
    assign play_valid = state_q == WPS_EXEC && ins.op == WPS_OP_PLAY;
    // Body ran once before the loop op is reached
    assign loop_init = ins.arg_a == '0 ? '0 : ins.arg_a - 16'h0001;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk)
    begin
        if (load_we)
            prog_q[load_addr] <= load_instr;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || load_we)
            loaded_q <= 1'b0;
        else if (load_done)
            loaded_q <= !load_error;
    end
    assign compile_ok_indicator = loaded_q;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || seq_reset)
        begin
            state_q <= WPS_IDLE;
            pc_q <= '0;
            loop_q <= '0;
            loop_v_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                WPS_IDLE:
                    if (start && loaded_q)
                    begin
                        state_q <= WPS_EXEC;
                        pc_q <= '0;
                    end
                WPS_EXEC:
                    case (ins.op)
                        WPS_OP_PLAY:
                            if (play_ready)
                                pc_q <= pc_q + 8'h01;
                        WPS_OP_WAIT:
                            state_q <= WPS_WAIT;
                        WPS_OP_LOOP:
                        begin
                            // Zero count loops forever
                            if (!loop_v_q && ins.arg_a == 16'h0001)
                                pc_q <= pc_q + 8'h01;
                            else if (!loop_v_q)
                            begin
                                loop_q <= loop_init;
                                loop_v_q <= 1'b1;
                                pc_q <= ins.target;
                            end
                            else if (loop_q == 16'h0001)
                            begin
                                loop_v_q <= 1'b0;
                                pc_q <= pc_q + 8'h01;
                            end
                            else
                            begin
                                if (loop_q != '0)
                                    loop_q <= loop_q - 16'h0001;
                                pc_q <= ins.target;
                            end
                        end
                        WPS_OP_JUMP:
                            pc_q <= ins.target;
                        WPS_OP_END:
                        begin
                            // Rerun restarts at once; outputs may gap
                            pc_q <= '0;
                            if (!rerun_en)
                                state_q <= WPS_IDLE;
                        end
                        default:
                            state_q <= WPS_IDLE;
                    endcase
                WPS_WAIT:
                    if (!busy)
                    begin
                        state_q <= WPS_EXEC;
                        pc_q <= pc_q + 8'h01;
                    end
                default:
                    state_q <= WPS_IDLE;
            endcase
        end
    end
    assign running = state_q != WPS_IDLE;

    ////////////////////////////////////////////////////////////////////
    // Trigger sources are asynchronous pins or units
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            trsync_q <= '0;
        end
        else
        begin
            s1_q <= trig_src;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Take a new level only once two stages agree
            trsync_q <= (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & trsync_q);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            trig_level <= '0;
        else
            for (int i = 0; i < `WPS_NTRIG; i++)
                trig_level[i] <=
                    trsync_q[trig_sel[i*`WPS_SEL_W +: `WPS_SEL_W]];
    end
    assign sel = trig_sel[`WPS_SEL_W-1:0];

    ////////////////////////////////////////////////////////////////////
    // Offset code to signed amplitude, then times the range
    // Full 32-bit product; a narrower one would wrap
    assign amp_prod = ($signed({18'h0, sample.analog}) -
        $signed({18'h0, `WPS_ANA_MID})) * $signed({16'h0, full_scale_level});

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            out_level <= '0;
        else
            out_level <= amp_prod[`WPS_AMP_SHIFT +: 16];
    end

    wps_player u_player
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .req_valid(play_valid),
        .req({ins.arg_a[`WPS_ADDR_W-1:0], ins.arg_b}),
        .req_ready(play_ready),
        .busy(busy),
        .mem_addr(mem_addr),
        .mem_data(mem_data),
        .sample(sample)
    );

    property p_wait_stall;
        @(posedge sys_clk) disable iff (!rst_b)
        state_q == WPS_WAIT && busy && !seq_reset |=> state_q == WPS_WAIT;
    endproperty
    a_wait_stall: assert property (p_wait_stall)
        else $error("wait left while playing");
    property p_wait_go;
        @(posedge sys_clk) disable iff (!rst_b)
        state_q == WPS_WAIT && !busy && !seq_reset |=>
        state_q == WPS_EXEC && pc_q == $past(pc_q) + 8'h01;
    endproperty
    a_wait_go: assert property (p_wait_go)
        else $error("wait did not resume");
    property p_once;
        @(posedge sys_clk) disable iff (!rst_b)
        state_q == WPS_EXEC && ins.op == WPS_OP_END && !rerun_en |=>
        !running;
    endproperty
    a_once: assert property (p_once)
        else $error("program did not stop");
    property p_rerun;
        @(posedge sys_clk) disable iff (!rst_b)
        state_q == WPS_EXEC && ins.op == WPS_OP_END && rerun_en &&
        !seq_reset |=> running && pc_q == 8'h00;
    endproperty
    a_rerun: assert property (p_rerun)
        else $error("rerun did not restart");
    property p_play_go;
        @(posedge sys_clk) disable iff (!rst_b)
        play_valid && play_ready && !seq_reset |=>
        pc_q == $past(pc_q) + 8'h01;
    endproperty
    a_play_go: assert property (p_play_go)
        else $error("play did not advance");
    property p_start_ok;
        @(posedge sys_clk) disable iff (!rst_b)
        !running && !loaded_q |=> !running;
    endproperty
    a_start_ok: assert property (p_start_ok)
        else $error("started without program");
    property p_ok_flag;
        @(posedge sys_clk) disable iff (!rst_b)
        load_done && !load_we && !load_error |=> compile_ok_indicator;
    endproperty
    a_ok_flag: assert property (p_ok_flag)
        else $error("load success not shown");
    property p_seq_rst;
        @(posedge sys_clk) disable iff (!rst_b)
        seq_reset |=> !running;
    endproperty
    a_seq_rst: assert property (p_seq_rst)
        else $error("sequencer reset did not stop");
    property p_trig;
        @(posedge sys_clk) disable iff (!rst_b)
        1'b1 |=> trig_level[0] == $past(trsync_q[sel]);
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger select wrong");
endmodule

// >>> tb/wps_mem_model.sv
`timescale 1ns/100ps
`include "wps_cfg.svh"

module wps_mem_model
(
    // Sample memory port
    mem_addr,
    mem_data
);
    input wire logic [`WPS_ADDR_W-1:0] mem_addr;
    output logic [`WPS_WORD_W-1:0] mem_data;

    // Word made from its own address, so every marker code shows up
    // Analog-only and marker-only waves merged, markers by OR
    assign mem_data = {mem_addr, mem_addr[3:2], 2'b00} |
        {14'h0000, mem_addr[1:0]};
endmodule

// >>> tb/testbench.sv
`timescale 1ns/100ps
`include "wps_cfg.svh"
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
    mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
    end end

module testbench;
    import wps_pkg::*;
    logic sys_clk, rst_b, load_we, load_done, load_error;
    logic start, rerun_en, seq_reset;
    logic [`WPS_PC_W-1:0] load_addr;
    wps_instr_t load_instr;
    logic compile_ok_indicator, running;
    logic [7:0] trig_src;
    logic [11:0] trig_sel;
    logic [3:0] trig_level;
    logic [15:0] full_scale_level;
    logic signed [15:0] out_level;
    logic [`WPS_ADDR_W-1:0] mem_addr;
    logic [`WPS_WORD_W-1:0] mem_data;
    wps_sample_t sample;
    wps_sample_t got_q[$];
    int at_q[$];
    int mismatches, n_tests, cyc;
    logic [13:0] pan;
    logic pv, pr;
    int e_lvl;

    wps_sequencer dut (.sys_clk(sys_clk), .rst_b(rst_b), .load_we(load_we),
        .load_addr(load_addr), .load_instr(load_instr),
        .load_done(load_done), .load_error(load_error),
        .compile_ok_indicator(compile_ok_indicator), .start(start),
        .rerun_en(rerun_en), .seq_reset(seq_reset), .running(running),
        .trig_src(trig_src), .trig_sel(trig_sel), .trig_level(trig_level),
        .full_scale_level(full_scale_level), .out_level(out_level),
        .mem_addr(mem_addr), .mem_data(mem_data), .sample(sample));
    wps_mem_model mem (.mem_addr(mem_addr), .mem_data(mem_data));

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Sample monitor, stamps each valid sample with its cycle
    always @(posedge sys_clk)
    begin
        cyc++;
        // Level lags the sample by one register stage
        if (pv === 1'b1 && pr === 1'b1)
        begin
            e_lvl = (int'(pan) - int'(`WPS_ANA_MID)) * int'(full_scale_level);
            e_lvl = e_lvl >>> `WPS_AMP_SHIFT;
            `CHK("out level", 16'(e_lvl), out_level)
        end
        pan = sample.analog;
        pv = sample.valid;
        pr = rst_b;
        if (sample.valid === 1'b1)
        begin
            got_q.push_back(sample);
            at_q.push_back(cyc);
        end
    end

    task close_out();
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task put(input int a, input wps_op_t op, input int t, input int x,
        input int y);
        @(posedge sys_clk);
        load_we <= 1'b1;
        load_addr <= 8'(a);
        load_instr <= '{op, 8'(t), 16'(x), 16'(y)};
    endtask

    task finish_load(input logic err);
        @(posedge sys_clk);
        load_we <= 1'b0;
        load_done <= 1'b1;
        load_error <= err;
        @(posedge sys_clk);
        load_done <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    // Start and wait, bounded, until the program has finished
    task run();
        int k;
        got_q.delete();
        at_q.delete();
        @(posedge sys_clk);
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        @(posedge sys_clk);
        for (k = 0; k < 2000 && running !== 1'b0; k++)
            @(posedge sys_clk);
        if (k == 2000)
        begin
            mismatches++;
            close_out();
        end
        repeat (4) @(posedge sys_clk);
    endtask

    // Padding past len is mid-code with markers low; no gaps allowed
    task check_wave(input int base, input int len, input int tot,
        input int reps);
        logic [11:0] a;
        int i;
        `CHK("count", tot * reps, got_q.size())
        if (got_q.size() != tot * reps)
            return;
        for (i = 0; i < tot * reps; i++)
        begin
            a = 12'(base + i % tot);
            if (i % tot < len)
            begin
                `CHK("analog", {a, a[3:2]}, got_q[i].analog)
                `CHK("marker", a[1:0], got_q[i].marker)
            end
            else
            begin
                `CHK("pad", `WPS_ANA_MID, got_q[i].analog)
                `CHK("pad marker", 2'h0, got_q[i].marker)
            end
            `CHK("gap", at_q[0] + i, at_q[i])
        end
    endtask

    task t_load_refuse();
        put(0, WPS_OP_PLAY, 0, 'h100, 16);
        put(1, WPS_OP_END, 0, 0, 0);
        finish_load(1'b1);
        `CHK("ok after error", 1'b0, compile_ok_indicator)
        run();
        `CHK("no play unloaded", 0, got_q.size())
        $display("t_load_refuse done");
    endtask

    task t_single_pad();
        put(0, WPS_OP_PLAY, 0, 'h100, 20);
        put(1, WPS_OP_JUMP, 3, 0, 0);
        put(2, WPS_OP_PLAY, 0, 'h700, 16);
        put(3, WPS_OP_WAIT, 0, 0, 0);
        put(4, WPS_OP_END, 0, 0, 0);
        finish_load(1'b0);
        `CHK("ok", 1'b1, compile_ok_indicator)
        run();
        `CHK("stopped", 1'b0, running)
        check_wave('h100, 20, 32, 1);
        $display("t_single_pad done");
    endtask

    task t_loop();
        put(0, WPS_OP_PLAY, 0, 'h200, 16);
        put(1, WPS_OP_LOOP, 0, 3, 0);
        put(2, WPS_OP_WAIT, 0, 0, 0);
        put(3, WPS_OP_END, 0, 0, 0);
        finish_load(1'b0);
        run();
        check_wave('h200, 16, 16, 3);
        $display("t_loop done");
    endtask

    task t_rerun();
        put(0, WPS_OP_PLAY, 0, 'h300, 16);
        put(1, WPS_OP_WAIT, 0, 0, 0);
        put(2, WPS_OP_END, 0, 0, 0);
        finish_load(1'b0);
        got_q.delete();
        @(posedge sys_clk);
        rerun_en <= 1'b1;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        repeat (150) @(posedge sys_clk);
        `CHK("rerun running", 1'b1, running)
        `CHK("replayed", 1'b1, got_q.size() >= 32)
        `CHK("restart word", 14'h0c00, got_q[16].analog)
        seq_reset <= 1'b1;
        rerun_en <= 1'b0;
        repeat (3) @(posedge sys_clk);
        seq_reset <= 1'b0;
        @(posedge sys_clk);
        `CHK("reset stops", 1'b0, running)
        $display("t_rerun done");
    endtask

    task t_trig();
        trig_sel <= {3'd7, 3'd2, 3'd1, 3'd0};
        trig_src <= 8'b1000_0010;
        repeat (8) @(posedge sys_clk);
        `CHK("trig a", 4'b1010, trig_level)
        trig_src <= 8'h7d;
        repeat (8) @(posedge sys_clk);
        `CHK("trig b", 4'b0101, trig_level)
        $display("t_trig done");
    endtask

    initial
    begin
        {rst_b, load_we, load_done, load_error, start} = '0;
        {rerun_en, seq_reset, load_addr, load_instr} = '0;
        {trig_src, trig_sel} = '0;
        full_scale_level = 16'h4000;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        `CHK("out level idle", 16'h0000, out_level)
        t_load_refuse();
        t_single_pad();
        t_loop();
        t_rerun();
        t_trig();
        close_out();
    end
endmodule
